/* File: logic/csf_pkg.sv */
// Constants and operation codes for the processor status flags register.
package csf_pkg;

  localparam int unsigned CSF_WIDTH     = 8;
  localparam int unsigned CSF_CARRY_BIT = 0;
  localparam int unsigned CSF_NIBBLE_BIT = 1;
  localparam int unsigned CSF_ZERO_BIT  = 2;
  localparam int unsigned CSF_PWRDN_BIT  = 3;
  localparam int unsigned CSF_EXPIRY_BIT = 4;
  localparam int unsigned CSF_BANK_LO_BIT = 5;
  localparam int unsigned CSF_BANK_HI_BIT = 6;
  localparam int unsigned CSF_PAGE_BIT   = 7;

  // Power-up value: both reset-cause flags high, the rest cleared.
  localparam logic [7:0] CSF_RESET_VALUE = 8'h18;
  // Bits that an instruction write always reaches.
  localparam logic [7:0] CSF_SW_MASK    = 8'he0;
  // Result flags, written only when the instruction leaves them alone.
  localparam logic [7:0] CSF_ALU_MASK   = 8'h07;

  localparam int unsigned CSF_BANK_BYTES = 128;
  localparam int unsigned CSF_ADDR_W     = 7;
  localparam int unsigned CSF_FULL_ADDR_W = 9;

  typedef enum logic [3:0] {
    CSF_OP_NOP        = 4'b0000,
    CSF_OP_MOVE       = 4'b0001,
    CSF_OP_BIT_CLEAR  = 4'b0010,
    CSF_OP_BIT_SET    = 4'b0011,
    CSF_OP_NIBBLE_X   = 4'b0100,
    CSF_OP_CLEAR_FILE = 4'b0101,
    CSF_OP_ADD        = 4'b0110,
    CSF_OP_SUB_FILE   = 4'b0111,
    CSF_OP_SUB_LIT    = 4'b1000,
    CSF_OP_AND        = 4'b1001,
    CSF_OP_OR         = 4'b1010,
    CSF_OP_XOR        = 4'b1011,
    CSF_OP_INC        = 4'b1100,
    CSF_OP_COMP       = 4'b1101
  } csf_op_t;

endpackage

/* File: logic/csf_flag_alu.sv */
// Result and flag generator for one instruction.
`timescale 1ns/1ps
module csf_flag_alu
  import csf_pkg::*;
(
  input  wire csf_op_t    op,
  input  wire logic [7:0] acc,
  input  wire logic [7:0] opnd,
  input  wire logic [2:0] bit_idx,
  output logic [7:0]      res,
  output logic            zero,
  output logic            nibble,
  output logic            carry,
  output logic            upd_zero,
  output logic            upd_nibble,
  output logic            upd_carry,
  output logic            writes_file
);

  logic [8:0] add_sum;
  logic [8:0] sub_sum;
  logic [4:0] add_lo;
  logic [4:0] sub_lo;
  logic [7:0] bit_sel;

  // Subtraction adds the inverted accumulator plus one, so carry out means no borrow.
  assign add_sum = {1'b0, opnd} + {1'b0, acc};
  assign sub_sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
  assign add_lo  = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
  assign sub_lo  = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
  assign bit_sel = 8'h01 << bit_idx;

  always_comb begin
    res         = opnd;
    carry       = 1'b0;
    nibble      = 1'b0;
    upd_zero    = 1'b0;
    upd_nibble  = 1'b0;
    upd_carry   = 1'b0;
    writes_file = 1'b1;
    case (op)
      CSF_OP_MOVE:       res = acc;
      CSF_OP_BIT_CLEAR:  res = opnd & ~bit_sel;
      CSF_OP_BIT_SET:    res = opnd | bit_sel;
      CSF_OP_NIBBLE_X:   res = {opnd[3:0], opnd[7:4]};
      CSF_OP_CLEAR_FILE: begin
        res      = 8'h00;
        upd_zero = 1'b1;
      end
      CSF_OP_ADD: begin
        res        = add_sum[7:0];
        carry      = add_sum[8];
        nibble     = add_lo[4];
        upd_zero   = 1'b1;
        upd_nibble = 1'b1;
        upd_carry  = 1'b1;
      end
      CSF_OP_SUB_FILE, CSF_OP_SUB_LIT: begin
        res         = sub_sum[7:0];
        carry       = sub_sum[8];
        nibble      = sub_lo[4];
        upd_zero    = 1'b1;
        upd_nibble  = 1'b1;
        upd_carry   = 1'b1;
        writes_file = (op == CSF_OP_SUB_FILE);
      end
      CSF_OP_AND: begin
        res      = opnd & acc;
        upd_zero = 1'b1;
      end
      CSF_OP_OR: begin
        res      = opnd | acc;
        upd_zero = 1'b1;
      end
      CSF_OP_XOR: begin
        res      = opnd ^ acc;
        upd_zero = 1'b1;
      end
      CSF_OP_INC: begin
        res      = opnd + 8'h01;
        upd_zero = 1'b1;
      end
      CSF_OP_COMP: begin
        res      = ~opnd;
        upd_zero = 1'b1;
      end
      default:           writes_file = 1'b0;
    endcase
    zero = (res == 8'h00);
  end

endmodule

/* File: logic/csf_status_reg.sv */
// Processor status flags register with bank select and reset-cause flags.
`timescale 1ns/1ps
module csf_status_reg
  import csf_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       exec,
  input  wire csf_op_t                    op,
  input  wire logic [7:0]                 acc_data,
  input  wire logic [7:0]                 file_data,
  input  wire logic [2:0]                 bit_idx,
  input  wire logic                       dest_status,
  input  wire logic                       watchdog_timeout,
  input  wire logic                       watchdog_clear_op,
  input  wire logic                       sleep_op,
  input  wire logic [CSF_ADDR_W-1:0]      direct_addr,
  input  wire logic [7:0]                 indirect_ptr,
  output logic [7:0]                      status,
  output logic                            carry_flag,
  output logic                            nibble_wrap_flag,
  output logic                            zero_flag,
  output logic                            power_down_flag,
  output logic                            watchdog_expiry_flag,
  output logic                            bank_select_low_bit,
  output logic                            bank_select_high_bit,
  output logic                            indirect_page_bit,
  output logic [7:0]                      result,
  output logic                            result_valid,
  output logic                            result_to_file,
  output logic [CSF_FULL_ADDR_W-1:0]      direct_full_addr,
  output logic [CSF_FULL_ADDR_W-1:0]      indirect_full_addr
);

  logic [7:0]                 status_q;
  logic [7:0]                 result_q;
  logic                       result_valid_q;
  logic                       result_to_file_q;
  logic [CSF_FULL_ADDR_W-1:0] direct_addr_q;
  logic [CSF_FULL_ADDR_W-1:0] indirect_addr_q;

  logic [7:0] operand;
  logic [7:0] alu_res;
  logic       alu_zero;
  logic       alu_nibble;
  logic       alu_carry;
  logic       upd_zero;
  logic       upd_nibble;
  logic       upd_carry;
  logic       writes_file;
  logic       status_write;
  logic       flags_touched;
  logic [7:0] write_mask;
  logic [7:0] write_d;
  logic [7:0] flag_mask;
  logic [7:0] flag_val;
  logic [7:0] status_d;
  logic       expiry_d;
  logic       power_down_d;

  // A status destination reads the register itself as the operand.
  assign operand = dest_status ? status_q : file_data;

  csf_flag_alu u_flag_alu (
    .op          (op),
    .acc         (acc_data),
    .opnd        (operand),
    .bit_idx     (bit_idx),
    .res         (alu_res),
    .zero        (alu_zero),
    .nibble      (alu_nibble),
    .carry       (alu_carry),
    .upd_zero    (upd_zero),
    .upd_nibble  (upd_nibble),
    .upd_carry   (upd_carry),
    .writes_file (writes_file)
  );

  assign status_write  = exec & dest_status & writes_file;
  assign flags_touched = upd_zero | upd_nibble | upd_carry;

  // Reset-cause bits never reach the write mask; result flags only when untouched.
  always_comb begin
    write_mask = CSF_SW_MASK;
    if (!flags_touched) begin
      write_mask = write_mask | CSF_ALU_MASK;
    end else begin
      write_mask = write_mask & ~CSF_ALU_MASK;
    end
  end

  assign write_d = status_write ? write_mask : 8'h00;

  always_comb begin
    flag_mask = 8'h00;
    flag_val  = 8'h00;
    if (exec) begin
      flag_mask[CSF_ZERO_BIT]   = upd_zero;
      flag_mask[CSF_NIBBLE_BIT] = upd_nibble;
      flag_mask[CSF_CARRY_BIT]  = upd_carry;
    end
    flag_val[CSF_ZERO_BIT]   = alu_zero;
    flag_val[CSF_NIBBLE_BIT] = alu_nibble;
    flag_val[CSF_CARRY_BIT]  = alu_carry;
  end

  // Clear-file lands as zero in the upper three bits and a set zero flag.
  always_comb begin
    status_d = status_q;
    status_d = (status_d & ~write_d) | (alu_res & write_d);
    status_d = (status_d & ~flag_mask) | (flag_val & flag_mask);
  end

  // A time-out in the same cycle as a clear or sleep wins, so the cause is kept.
  always_comb begin
    expiry_d = status_q[CSF_EXPIRY_BIT];
    if (watchdog_timeout) begin
      expiry_d = 1'b0;
    end else if (watchdog_clear_op || sleep_op) begin
      expiry_d = 1'b1;
    end
  end

  // Sleep is taken as the last word when it meets a watchdog clear.
  always_comb begin
    power_down_d = status_q[CSF_PWRDN_BIT];
    if (sleep_op) begin
      power_down_d = 1'b0;
    end else if (watchdog_clear_op) begin
      power_down_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      status_q <= CSF_RESET_VALUE;
    end else begin
      status_q[CSF_PAGE_BIT]    <= status_d[CSF_PAGE_BIT];
      status_q[CSF_BANK_HI_BIT] <= status_d[CSF_BANK_HI_BIT];
      status_q[CSF_BANK_LO_BIT] <= status_d[CSF_BANK_LO_BIT];
      status_q[CSF_EXPIRY_BIT]  <= expiry_d;
      status_q[CSF_PWRDN_BIT]   <= power_down_d;
      status_q[CSF_ZERO_BIT]    <= status_d[CSF_ZERO_BIT];
      status_q[CSF_NIBBLE_BIT]  <= status_d[CSF_NIBBLE_BIT];
      status_q[CSF_CARRY_BIT]   <= status_d[CSF_CARRY_BIT];
    end
  end

  // Result goes to the file or accumulator named by the core; status writes land above.
  always_ff @(posedge clock) begin
    if (rst) begin
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= exec & (op != CSF_OP_NOP);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      result_to_file_q <= 1'b0;
    end else begin
      result_to_file_q <= exec & writes_file & ~dest_status;
    end
  end

  // Result holds between instructions so a late reader still sees it.
  always_ff @(posedge clock) begin
    if (rst) begin
      result_q <= 8'h00;
    end else if (exec) begin
      result_q <= alu_res;
    end
  end

  // Address expansion uses the bank bits as they stand after this edge's write,
  // so a bank switch is seen by the very next access.
  always_ff @(posedge clock) begin
    if (rst) begin
      direct_addr_q <= '0;
    end else begin
      direct_addr_q <= {status_d[CSF_BANK_HI_BIT], status_d[CSF_BANK_LO_BIT],
                        direct_addr};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      indirect_addr_q <= '0;
    end else begin
      indirect_addr_q <= {status_d[CSF_PAGE_BIT], indirect_ptr};
    end
  end

  assign status               = status_q;
  assign carry_flag           = status_q[CSF_CARRY_BIT];
  assign nibble_wrap_flag     = status_q[CSF_NIBBLE_BIT];
  assign zero_flag            = status_q[CSF_ZERO_BIT];
  assign power_down_flag      = status_q[CSF_PWRDN_BIT];
  assign watchdog_expiry_flag = status_q[CSF_EXPIRY_BIT];
  assign bank_select_low_bit  = status_q[CSF_BANK_LO_BIT];
  assign bank_select_high_bit = status_q[CSF_BANK_HI_BIT];
  assign indirect_page_bit    = status_q[CSF_PAGE_BIT];
  assign result               = result_q;
  assign result_valid         = result_valid_q;
  assign result_to_file       = result_to_file_q;
  assign direct_full_addr     = direct_addr_q;
  assign indirect_full_addr   = indirect_addr_q;

endmodule

/* File: test/csf_status_reg_monitor.sv */
// Port-level assertions for the processor status flags register.
`timescale 1ns/1ps
module csf_status_reg_monitor
  import csf_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       exec,
  input wire csf_op_t    op,
  input wire logic [7:0] acc_data,
  input wire logic [7:0] file_data,
  input wire logic       dest_status,
  input wire logic       watchdog_timeout,
  input wire logic       watchdog_clear_op,
  input wire logic       sleep_op,
  input wire logic [6:0] direct_addr,
  input wire logic [7:0] status,
  input wire logic       carry_flag,
  input wire logic       nibble_wrap_flag,
  input wire logic       zero_flag,
  input wire logic       power_down_flag,
  input wire logic       watchdog_expiry_flag,
  input wire logic       bank_select_low_bit,
  input wire logic       bank_select_high_bit,
  input wire logic       indirect_page_bit,
  input wire logic       result_valid,
  input wire logic [8:0] direct_full_addr
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Cause flags may move on their own, so lock checks exclude those pulses
  sequence s_quiet;
    !watchdog_timeout && !watchdog_clear_op && !sleep_op;
  endsequence
  sequence s_status_write;
    exec && dest_status;
  endsequence
  sequence s_sleep;
    sleep_op && !watchdog_timeout;
  endsequence

  chk_reset_value: assert property (
    $fell(rst) |-> status == CSF_RESET_VALUE && !result_valid)
    else $error("status not at power-up value");
  chk_flag_mirror: assert property (status == {indirect_page_bit, bank_select_high_bit,
    bank_select_low_bit, watchdog_expiry_flag, power_down_flag, zero_flag, nibble_wrap_flag,
    carry_flag}) else $error("flag outputs differ from status");
  chk_cause_locked: assert property (s_status_write ##0 s_quiet |=>
    status[4:3] == $past(status[4:3])) else $error("reset-cause flags written");
  chk_move_store: assert property (exec && op == CSF_OP_MOVE && dest_status |=>
    {status[7:5], status[2:0]} == {$past(acc_data[7:5]), $past(acc_data[2:0])})
    else $error("move to status not stored");
  chk_clear_file: assert property (exec && op == CSF_OP_CLEAR_FILE && dest_status |=>
    status[7:5] == 3'h0 && zero_flag && status[1:0] == $past(status[1:0]))
    else $error("clear of status wrong");
  chk_sub_borrow: assert property (exec && op == CSF_OP_SUB_LIT |=>
    carry_flag == ($past(file_data) >= $past(acc_data)) &&
    nibble_wrap_flag == ($past(file_data[3:0]) >= $past(acc_data[3:0])))
    else $error("subtract borrow flags wrong");
  chk_timeout_clear: assert property (watchdog_timeout |=> !watchdog_expiry_flag)
    else $error("expiry flag not cleared on time-out");
  chk_sleep_flags: assert property (s_sleep |=>
    watchdog_expiry_flag && !power_down_flag) else $error("sleep flags wrong");
  chk_watchdog_restart: assert property (
    watchdog_clear_op && !sleep_op && !watchdog_timeout |=>
    watchdog_expiry_flag && power_down_flag) else $error("watchdog clear flags wrong");
  chk_bank_addr: assert property (1'b1 |=>
    direct_full_addr == {status[6:5], $past(direct_addr)}) else $error("bank address wrong");
  chk_result_pulse: assert property (exec && op != CSF_OP_NOP |=> result_valid)
    else $error("result valid missing");
endmodule

/* File: test/csf_status_reg_tb_top.sv */
// Directed bench for the processor status flags register.
`timescale 1ns/1ps
module csf_status_reg_tb_top import csf_pkg::*;;
  logic       clock, rst, exec, dest_status, watchdog_timeout, watchdog_clear_op, sleep_op;
  csf_op_t    op;
  logic [7:0] acc_data, file_data, indirect_ptr, status, result, d;
  logic [2:0] bit_idx;
  logic [6:0] direct_addr;
  logic       carry_flag, nibble_wrap_flag, zero_flag, power_down_flag, watchdog_expiry_flag;
  logic       bank_select_low_bit, bank_select_high_bit, indirect_page_bit;
  logic       result_valid, result_to_file;
  logic [8:0] direct_full_addr, indirect_full_addr;
  int         fails, num_checks, cycles;
  logic [7:0] ta [4] = '{8'h03, 8'h05, 8'h05, 8'h01};
  logic [7:0] tf [4] = '{8'h05, 8'h03, 8'h05, 8'h10};

  csf_status_reg uut (.clock, .rst, .exec, .op, .acc_data, .file_data, .bit_idx, .dest_status,
    .watchdog_timeout, .watchdog_clear_op, .sleep_op, .direct_addr, .indirect_ptr, .status,
    .carry_flag, .nibble_wrap_flag, .zero_flag, .power_down_flag, .watchdog_expiry_flag,
    .bank_select_low_bit, .bank_select_high_bit, .indirect_page_bit, .result, .result_valid,
    .result_to_file, .direct_full_addr, .indirect_full_addr);

  always #12.5 clock = ~clock;

  // Inputs change at the falling edge; one call is one instruction cycle
  task automatic step(input csf_op_t o, input logic [7:0] a, input logic [7:0] f,
                      input logic [2:0] b, input logic ds, input logic [2:0] w);
    exec = (o != CSF_OP_NOP);
    op = o;
    acc_data = a;
    file_data = f;
    bit_idx = b;
    dest_status = ds;
    {watchdog_timeout, watchdog_clear_op, sleep_op} = w;
    @(negedge clock);
  endtask

  task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task summarize;
    $display("Checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run is under a hundred cycles; the ceiling leaves wide margin
  always @(posedge clock) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      summarize();
    end
  end

  initial begin
    clock = 0; rst = 1; exec = 0; op = CSF_OP_NOP; acc_data = 8'h00; file_data = 8'h00;
    bit_idx = 3'h0; dest_status = 0; watchdog_timeout = 0; watchdog_clear_op = 0;
    sleep_op = 0; direct_addr = 7'h55; indirect_ptr = 8'h9a; fails = 0; num_checks = 0;
    cycles = 0;
    repeat (8) @(negedge clock);
    rst = 0;
    @(negedge clock);
    chk("status", 9'h018, {1'b0, status});
    chk("valid", 9'h000, {8'h00, result_valid});
    step(CSF_OP_MOVE, 8'he7, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h0ff, {1'b0, status});
    chk("direct", 9'h1d5, direct_full_addr);
    chk("indirect", 9'h19a, indirect_full_addr);
    step(CSF_OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h01f, {1'b0, status});
    chk("valid", 9'h001, {8'h00, result_valid});
    step(CSF_OP_BIT_SET, 8'h00, 8'h00, 3'h5, 1, 3'h0);
    chk("status", 9'h03f, {1'b0, status});
    step(CSF_OP_BIT_CLEAR, 8'h00, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h03e, {1'b0, status});
    chk("direct", 9'h0d5, direct_full_addr);
    step(CSF_OP_NIBBLE_X, 8'h00, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h0fb, {1'b0, status});
    // Sum equals old status, so a leaked write would show 011 in the low bits
    step(CSF_OP_ADD, 8'h00, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h0f8, {1'b0, status});
    // Software puts bits seven to five back to zero before going on
    step(CSF_OP_MOVE, 8'h00, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h018, {1'b0, status});
    step(CSF_OP_NOP, 8'h00, 8'h00, 3'h0, 0, 3'b100);
    chk("status", 9'h008, {1'b0, status});
    step(CSF_OP_MOVE, 8'h10, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h008, {1'b0, status});
    step(CSF_OP_NOP, 8'h00, 8'h00, 3'h0, 0, 3'b010);
    chk("status", 9'h018, {1'b0, status});
    step(CSF_OP_NOP, 8'h00, 8'h00, 3'h0, 0, 3'b001);
    chk("status", 9'h010, {1'b0, status});
    step(CSF_OP_NOP, 8'h00, 8'h00, 3'h0, 0, 3'b110);
    chk("status", 9'h008, {1'b0, status});
    step(CSF_OP_ADD, 8'h01, 8'hff, 3'h0, 0, 3'h0);
    chk("status", 9'h00f, {1'b0, status});
    chk("to_file", 9'h001, {8'h00, result_to_file});
    for (int i = 0; i < 4; i++) begin
      step(i == 0 ? CSF_OP_SUB_FILE : CSF_OP_SUB_LIT, ta[i], tf[i], 3'h0, 0, 3'h0);
      d = tf[i] - ta[i];
      chk("result", {1'b0, d}, {1'b0, result});
      chk("status", {6'h01, d == 8'h00, tf[i][3:0] >= ta[i][3:0], tf[i] >= ta[i]},
          {1'b0, status});
    end
    // Logic ops move only the zero flag; carry stays set from the last subtraction
    step(CSF_OP_AND, 8'h0f, 8'hf0, 3'h0, 0, 3'h0);
    chk("result", 9'h000, {1'b0, result});
    chk("status", 9'h00d, {1'b0, status});
    step(CSF_OP_OR, 8'h01, 8'h00, 3'h0, 0, 3'h0);
    chk("result", 9'h001, {1'b0, result});
    chk("status", 9'h009, {1'b0, status});
    step(CSF_OP_INC, 8'h00, 8'hff, 3'h0, 0, 3'h0);
    chk("result", 9'h000, {1'b0, result});
    chk("status", 9'h00d, {1'b0, status});
    step(CSF_OP_COMP, 8'h00, 8'h00, 3'h0, 0, 3'h0);
    chk("result", 9'h0ff, {1'b0, result});
    chk("status", 9'h009, {1'b0, status});
    // Result 04 on status: a leaked write would show 100 in the low bits
    step(CSF_OP_XOR, 8'h0d, 8'h00, 3'h0, 1, 3'h0);
    chk("status", 9'h009, {1'b0, status});
    chk("to_file", 9'h000, {8'h00, result_to_file});
    step(CSF_OP_NOP, 8'h00, 8'h00, 3'h0, 0, 3'b100);
    chk("status", 9'h009, {1'b0, status});
    // Watchdog pulses drop with reset so the release edge sees a quiet core
    rst = 1;
    {watchdog_timeout, watchdog_clear_op, sleep_op} = 3'h0;
    @(negedge clock);
    rst = 0;
    @(negedge clock);
    chk("status", 9'h018, {1'b0, status});
    summarize();
  end
endmodule

bind csf_status_reg csf_status_reg_monitor u_mon (.clock, .rst, .exec, .op, .acc_data,
  .file_data, .dest_status, .watchdog_timeout, .watchdog_clear_op, .sleep_op, .direct_addr,
  .status, .carry_flag, .nibble_wrap_flag, .zero_flag, .power_down_flag, .watchdog_expiry_flag,
  .bank_select_low_bit, .bank_select_high_bit, .indirect_page_bit, .result_valid,
  .direct_full_addr);
